//--- swr_dev_model.sv
`timescale 1ns/1ps

module swr_dev_model #(
  // Arbitrary identity value
  parameter logic [63:0] ID = 64'h5a3c_0f96_d2e1_7b48
) (
  // Line
  input wire logic line_in,
  input wire logic present_in,
  output logic pull_n_out
);
  // States; the memory phase is not modelled and sits in idle
  localparam int IDLE = 0;
  localparam int CMD = 1;
  localparam int SEND = 2;
  localparam int SRCH = 3;
  localparam int MTCH = 4;
  int st = IDLE;
  int n = 0;
  int ph = 0;
  logic fast = 1'b0;
  logic pull_r = 1'b1;
  logic tx, txb, rxb;
  logic [7:0] cb = 8'h00;
  realtime t0, d;

  assign pull_n_out = pull_r | !present_in;

  always begin
    @(negedge line_in);
    t0 = $realtime;
    tx = (st == SEND) || (st == SRCH && ph < 2);
    txb = ID[n] ^ (st == SRCH && ph == 1);
    if (tx && !txb) begin
      pull_r = 1'b0;
      #(fast ? 2500 : 12400);
      pull_r = 1'b1;
    end else begin
      #(fast ? 3000 : 7000);
      rxb = line_in;
    end
    if (line_in !== 1'b1) @(posedge line_in);
    d = $realtime - t0;
    if (d >= 14000 || (fast && d >= 6600)) begin
      // Only a regular-length low leaves fast speed; a fast reset keeps it
      if (d >= 50000) fast = 1'b0;
      st = CMD;
      n = 0;
      #(fast ? 2000 : 4000);
      pull_r = 1'b0;
      #(fast ? 7000 : 8000);
      pull_r = 1'b1;
    end else if (st == CMD) begin
      cb = {rxb, cb[7:1]};
      n++;
      if (n == 8) begin
        n = 0;
        ph = 0;
        st = IDLE;
        if (cb == 8'h33) st = SEND;
        if (cb == 8'hf0) st = SRCH;
        if (cb == 8'h55 || cb == 8'h69) st = MTCH;
        if (cb == 8'h3c) fast = 1'b1;
      end
    end else if (st == SEND) begin
      n++;
      if (n == 64) st = IDLE;
    end else if (st == SRCH) begin
      if (ph == 2 && rxb != ID[n]) st = IDLE;
      if (ph == 2) n++;
      ph = (ph == 2) ? 0 : ph + 1;
    end else if (st == MTCH) begin
      if (rxb != ID[n]) st = IDLE;
      n++;
      if (n == 64 && st == MTCH && cb == 8'h69) fast = 1'b1;
      if (n == 64) st = IDLE;
    end
  end
endmodule : swr_dev_model

//--- swr_fifo.sv
`timescale 1ns/1ps

module swr_fifo #(
  parameter int W = 10,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // Fill side
  input wire logic in_valid_in,
  input wire logic [W-1:0] in_data_in,
  output logic in_ready_out,
  // Drain side
  output logic out_valid_out,
  output logic [W-1:0] out_data_out,
  input wire logic out_ready_in
);

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_ff [DEPTH];
  logic [AW:0] wr_ptr_ff;
  logic [AW:0] rd_ptr_ff;
  logic [AW:0] fill;
  logic push;
  logic pop;

  assign fill = wr_ptr_ff - rd_ptr_ff;
  assign in_ready_out = (fill != (AW+1)'(DEPTH));
  assign out_valid_out = (fill != '0);
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;
  assign out_data_out = mem_ff[rd_ptr_ff[AW-1:0]];

  // --------------------------------------------------------------------
  // Storage, one flop row per entry
  // --------------------------------------------------------------------
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
        mem_ff[i] <= '0;
      end else if (push && (wr_ptr_ff[AW-1:0] == AW'(i))) begin
        mem_ff[i] <= in_data_in;
      end
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      wr_ptr_ff <= wr_ptr_ff + (AW+1)'(push);
      rd_ptr_ff <= rd_ptr_ff + (AW+1)'(pop);
    end
  end

endmodule : swr_fifo

//--- swr_map.svh
`ifndef SWR_MAP_SVH
`define SWR_MAP_SVH

// ----------------------------------------------------------------------
// Clock and conversion of times to cycles
// ----------------------------------------------------------------------
`define SWR_CLK_MHZ 250
`define SWR_CYC_MIN(ns) ((((ns) * `SWR_CLK_MHZ) + 999) / 1000)
`define SWR_CYC_MAX(ns) (((ns) * `SWR_CLK_MHZ) / 1000)

// ----------------------------------------------------------------------
// ROM function command codes
// ----------------------------------------------------------------------
`define SWR_CMD_READ_ID 8'h33
`define SWR_CMD_MATCH 8'h55
`define SWR_CMD_SKIP 8'hcc
`define SWR_CMD_SEARCH 8'hf0
`define SWR_CMD_FAST_SKIP 8'h3c
`define SWR_CMD_FAST_MATCH 8'h69

// ----------------------------------------------------------------------
// Regular speed times, ns
// ----------------------------------------------------------------------
`define SWR_RST_LOW_REG_NS 480000
`define SWR_RST_HIGH_REG_NS 480000
`define SWR_PRES_SAMP_REG_NS 70000
`define SWR_LOW1_REG_NS 6000
`define SWR_LOW0_REG_NS 60000
`define SWR_LOWR_REG_NS 1000
`define SWR_RD_SAMP_REG_NS 12000
`define SWR_SLOT_REG_NS 70000

// ----------------------------------------------------------------------
// Fast speed times, ns
// ----------------------------------------------------------------------
`define SWR_RST_LOW_FAST_NS 48000
`define SWR_RST_HIGH_FAST_NS 48000
`define SWR_PRES_SAMP_FAST_NS 8000
`define SWR_LOW1_FAST_NS 1000
`define SWR_LOW0_FAST_NS 6000
`define SWR_LOWR_FAST_NS 1000
`define SWR_RD_SAMP_FAST_NS 1500
`define SWR_SLOT_FAST_NS 8000

// ----------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------
`define SWR_BITS_PER_BYTE 4'h8
`define SWR_FIFO_DEPTH 16

`endif

//--- swr_master.sv
`timescale 1ns/1ps
`include "swr_map.svh"

module swr_master #(
  parameter int CW = 17,
  parameter int FIFO_DEPTH = `SWR_FIFO_DEPTH,
  parameter logic [CW-1:0] RST_LOW_REG = CW'(`SWR_CYC_MIN(`SWR_RST_LOW_REG_NS)),
  parameter logic [CW-1:0] RST_HIGH_REG =
    CW'(`SWR_CYC_MIN(`SWR_RST_HIGH_REG_NS)),
  parameter logic [CW-1:0] PRES_SAMP_REG =
    CW'(`SWR_CYC_MIN(`SWR_PRES_SAMP_REG_NS)),
  parameter logic [CW-1:0] RST_LOW_FAST =
    CW'(`SWR_CYC_MIN(`SWR_RST_LOW_FAST_NS)),
  parameter logic [CW-1:0] RST_HIGH_FAST =
    CW'(`SWR_CYC_MIN(`SWR_RST_HIGH_FAST_NS)),
  parameter logic [CW-1:0] LOW0_REG = CW'(`SWR_CYC_MIN(`SWR_LOW0_REG_NS)),
  parameter logic [CW-1:0] SLOT_REG = CW'(`SWR_CYC_MIN(`SWR_SLOT_REG_NS)),
  parameter logic [CW-1:0] SLOT_FAST = CW'(`SWR_CYC_MIN(`SWR_SLOT_FAST_NS))
) (
  // Clock and reset
  input wire logic CLK_SYS_IN,
  input wire logic RESET_N_IN,
  // Command port
  input wire logic CMD_VALID_IN,
  input wire swr_pkg::swr_cmd_s CMD_IN,
  output logic CMD_READY_OUT,
  // Response port
  output logic RSP_VALID_OUT,
  output swr_pkg::swr_rsp_s RSP_OUT,
  input wire logic RSP_READY_IN,
  // Single-wire bus pin
  input wire logic BUS_IN,
  output logic BUS_OUT,
  output logic BUS_OE_N_OUT,
  // Status
  output logic FAST_SPEED_OUT,
  output logic BUSY_OUT
);

  // --------------------------------------------------------------------
  // Short timing counts
  // --------------------------------------------------------------------
  localparam logic [CW-1:0] PRES_SAMP_FAST =
    CW'(`SWR_CYC_MIN(`SWR_PRES_SAMP_FAST_NS));
  localparam logic [CW-1:0] LOW1_REG = CW'(`SWR_CYC_MIN(`SWR_LOW1_REG_NS));
  localparam logic [CW-1:0] LOW1_FAST = CW'(`SWR_CYC_MIN(`SWR_LOW1_FAST_NS));
  localparam logic [CW-1:0] LOW0_FAST = CW'(`SWR_CYC_MIN(`SWR_LOW0_FAST_NS));
  localparam logic [CW-1:0] LOWR_REG = CW'(`SWR_CYC_MIN(`SWR_LOWR_REG_NS));
  localparam logic [CW-1:0] LOWR_FAST = CW'(`SWR_CYC_MIN(`SWR_LOWR_FAST_NS));
  localparam logic [CW-1:0] RD_SAMP_REG =
    CW'(`SWR_CYC_MAX(`SWR_RD_SAMP_REG_NS));
  localparam logic [CW-1:0] RD_SAMP_FAST =
    CW'(`SWR_CYC_MAX(`SWR_RD_SAMP_FAST_NS));

  typedef enum logic [1:0] {ST_IDLE, ST_RST_LOW, ST_RST_HIGH, ST_SLOT}
    swr_state_e;

  swr_state_e state_ff;
  swr_state_e nxt_state;
  swr_pkg::swr_op_e op_ff;
  logic [7:0] shreg_ff;
  logic [3:0] bit_ff;
  logic [CW-1:0] cnt_ff;
  logic fast_ff;
  logic rom_phase_ff;
  logic pref_ff;
  logic id_bit_ff;
  logic cmp_bit_ff;
  logic samp_ff;
  logic drive_ff;
  logic push_ff;
  swr_pkg::swr_rsp_s push_data_ff;
  logic bus_meta_ff;
  logic bus_sync_ff;
  logic fifo_ready;

  // --------------------------------------------------------------------
  // Pin synchroniser
  // --------------------------------------------------------------------
  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      bus_meta_ff <= 1'b1;
      bus_sync_ff <= 1'b1;
    end else begin
      bus_meta_ff <= BUS_IN;
      bus_sync_ff <= bus_meta_ff;
    end
  end

  // --------------------------------------------------------------------
  // Speed-dependent timing selection
  // --------------------------------------------------------------------
  wire [CW-1:0] t_rst_low = fast_ff ? RST_LOW_FAST : RST_LOW_REG;
  wire [CW-1:0] t_rst_high = fast_ff ? RST_HIGH_FAST : RST_HIGH_REG;
  wire [CW-1:0] t_pres_samp = fast_ff ? PRES_SAMP_FAST : PRES_SAMP_REG;
  wire [CW-1:0] t_low1 = fast_ff ? LOW1_FAST : LOW1_REG;
  wire [CW-1:0] t_low0 = fast_ff ? LOW0_FAST : LOW0_REG;
  wire [CW-1:0] t_lowr = fast_ff ? LOWR_FAST : LOWR_REG;
  wire [CW-1:0] t_rd_samp = fast_ff ? RD_SAMP_FAST : RD_SAMP_REG;
  wire [CW-1:0] t_slot = fast_ff ? SLOT_FAST : SLOT_REG;

  // --------------------------------------------------------------------
  // Slot decode
  // --------------------------------------------------------------------
  wire is_trip = (op_ff == swr_pkg::SWR_OP_TRIPLET);
  wire trip_write = is_trip && (bit_ff == 4'h2);
  wire slot_is_write = (op_ff == swr_pkg::SWR_OP_WRITE) || trip_write;
  // Search direction: follow the unanimous bit, else the preferred one
  wire trip_dir = (id_bit_ff != cmp_bit_ff) ? id_bit_ff : pref_ff;
  wire wr_bit = is_trip ? trip_dir : shreg_ff[0];
  wire [CW-1:0] slot_low = slot_is_write ? (wr_bit ? t_low1 : t_low0)
                                         : t_lowr;
  wire slot_end = (state_ff == ST_SLOT) && (cnt_ff == t_slot - 1'b1);
  wire samp_now = (state_ff == ST_SLOT) && !slot_is_write &&
                  (cnt_ff == t_rd_samp);
  wire rsth_end = (state_ff == ST_RST_HIGH) &&
                  (cnt_ff == t_rst_high - 1'b1);
  wire rstl_end = (state_ff == ST_RST_LOW) && (cnt_ff == t_rst_low - 1'b1);
  wire last_step = is_trip ? (bit_ff == 4'h2)
                           : (bit_ff == `SWR_BITS_PER_BYTE - 4'h1);
  wire op_done = slot_end && last_step;
  wire take = CMD_VALID_IN && CMD_READY_OUT;
  wire rom_code = rom_phase_ff && (op_ff == swr_pkg::SWR_OP_WRITE);
  // Writes rotate, so the whole code byte is in view at the last slot
  wire [7:0] wr_rot = {shreg_ff[0], shreg_ff[7:1]};
  // Identity exchange after a fast match must already run fast
  wire go_fast = op_done && rom_code &&
                 ((wr_rot == `SWR_CMD_FAST_SKIP) ||
                  (wr_rot == `SWR_CMD_FAST_MATCH));
  wire [7:0] rd_shift = {samp_ff, shreg_ff[7:1]};

  // Only one answer per command, but the last answer is pushed in the first idle cycle, so a take there can find no room at its own push
  assign CMD_READY_OUT = (state_ff == ST_IDLE) && fifo_ready;
  assign BUSY_OUT = (state_ff != ST_IDLE);
  assign FAST_SPEED_OUT = fast_ff;
  assign BUS_OUT = 1'b0;
  assign BUS_OE_N_OUT = !drive_ff;

  // --------------------------------------------------------------------
  // State machine
  // --------------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (take) begin
          if ((CMD_IN.op == swr_pkg::SWR_OP_RESET) ||
              (CMD_IN.op == swr_pkg::SWR_OP_RESET_REG)) begin
            nxt_state = ST_RST_LOW;
          end else begin
            nxt_state = ST_SLOT;
          end
        end
      end
      ST_RST_LOW: begin
        if (rstl_end) begin
          nxt_state = ST_RST_HIGH;
        end
      end
      ST_RST_HIGH: begin
        if (rsth_end) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_SLOT: begin
        if (op_done) begin
          nxt_state = ST_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      state_ff <= ST_IDLE;
      cnt_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      if (take || rstl_end || slot_end) begin
        cnt_ff <= '0;
      end else if (state_ff != ST_IDLE) begin
        cnt_ff <= cnt_ff + 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------
  // Line drive: low only in reset low or the front of a slot
  // --------------------------------------------------------------------
  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      drive_ff <= 1'b0;
    end else begin
      drive_ff <= (nxt_state == ST_RST_LOW) ||
                  ((nxt_state == ST_SLOT) && !slot_end && !take &&
                   (cnt_ff + 1'b1 < slot_low)) ||
                  (take && (nxt_state == ST_SLOT));
    end
  end

  // --------------------------------------------------------------------
  // Command capture, shifting and speed flag
  // --------------------------------------------------------------------
  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      op_ff <= swr_pkg::SWR_OP_RESET;
      shreg_ff <= '0;
      bit_ff <= '0;
      pref_ff <= 1'b0;
      fast_ff <= 1'b0;
      rom_phase_ff <= 1'b0;
    end else begin
      if (take) begin
        op_ff <= CMD_IN.op;
        shreg_ff <= CMD_IN.data;
        pref_ff <= CMD_IN.data[0];
        bit_ff <= '0;
      end else if (slot_end) begin
        bit_ff <= bit_ff + 4'h1;
        if (op_ff == swr_pkg::SWR_OP_WRITE) begin
          shreg_ff <= wr_rot;
        end else if (op_ff == swr_pkg::SWR_OP_READ) begin
          shreg_ff <= rd_shift;
        end
      end
      if (take && (CMD_IN.op == swr_pkg::SWR_OP_RESET_REG)) begin
        fast_ff <= 1'b0;
      end else if (go_fast) begin
        fast_ff <= 1'b1;
      end
      if (rsth_end) begin
        rom_phase_ff <= 1'b1;
      end else if (op_done) begin
        rom_phase_ff <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // Line sampling and answers
  // --------------------------------------------------------------------
  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      samp_ff <= 1'b1;
      id_bit_ff <= 1'b0;
      cmp_bit_ff <= 1'b0;
      push_ff <= 1'b0;
      push_data_ff <= '0;
    end else begin
      push_ff <= 1'b0;
      if (samp_now) begin
        samp_ff <= bus_sync_ff;
        if (is_trip && (bit_ff == 4'h0)) begin
          id_bit_ff <= bus_sync_ff;
        end
        if (is_trip && (bit_ff == 4'h1)) begin
          cmp_bit_ff <= bus_sync_ff;
        end
      end
      if ((state_ff == ST_RST_HIGH) && (cnt_ff == t_pres_samp)) begin
        samp_ff <= bus_sync_ff;
      end
      if (rsth_end) begin
        push_ff <= 1'b1;
        push_data_ff <= '{kind: swr_pkg::SWR_RSP_PRESENCE,
                          data: {7'h00, !samp_ff}};
      end else if (op_done && (op_ff == swr_pkg::SWR_OP_READ)) begin
        push_ff <= 1'b1;
        push_data_ff <= '{kind: swr_pkg::SWR_RSP_BYTE, data: rd_shift};
      end else if (op_done && is_trip) begin
        push_ff <= 1'b1;
        push_data_ff <= '{kind: swr_pkg::SWR_RSP_TRIPLET,
                          data: {5'h00, trip_dir, cmp_bit_ff, id_bit_ff}};
      end
    end
  end

  // --------------------------------------------------------------------
  // Answer buffer; a full buffer holds off new commands
  // --------------------------------------------------------------------
  swr_fifo #(
    .W($bits(swr_pkg::swr_rsp_s)),
    .DEPTH(FIFO_DEPTH)
  ) u_rsp_fifo (
    .clk_in(CLK_SYS_IN),
    .reset_n_in(RESET_N_IN),
    .in_valid_in(push_ff),
    .in_data_in(push_data_ff),
    .in_ready_out(fifo_ready),
    .out_valid_out(RSP_VALID_OUT),
    .out_data_out(RSP_OUT),
    .out_ready_in(RSP_READY_IN)
  );

endmodule : swr_master

//--- swr_master_chk.sv
`timescale 1ns/1ps

module swr_master_chk #(
  parameter int CW = 17,
  parameter logic [CW-1:0] LOW0_REG = 1,
  parameter logic [CW-1:0] RST_LOW_REG = 1,
  parameter logic [CW-1:0] RST_HIGH_REG = 1,
  parameter logic [CW-1:0] RST_HIGH_FAST = 1
) (
  // Clock and reset
  input wire logic CLK_SYS_IN,
  input wire logic RESET_N_IN,
  // Watched ports
  input wire logic CMD_VALID_IN,
  input wire logic CMD_READY_OUT,
  input wire logic RSP_VALID_OUT,
  input wire swr_pkg::swr_rsp_s RSP_OUT,
  input wire logic RSP_READY_IN,
  input wire logic BUS_OE_N_OUT,
  input wire logic FAST_SPEED_OUT,
  input wire logic BUSY_OUT
);
  logic [CW-1:0] low_cnt_ff;
  logic [CW-1:0] high_cnt_ff;
  logic after_rst_ff;
  logic long_low;
  logic take;

  default clocking cb @(posedge CLK_SYS_IN);
  endclocking
  default disable iff (!RESET_N_IN);

  // A low longer than any write-zero slot can only be a reset pulse
  assign long_low = low_cnt_ff > LOW0_REG + 2;
  assign take = CMD_VALID_IN && CMD_READY_OUT;

  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      low_cnt_ff <= '0;
      high_cnt_ff <= '0;
      after_rst_ff <= 1'b0;
    end else begin
      low_cnt_ff <= BUS_OE_N_OUT ? '0 : low_cnt_ff + 1'b1;
      high_cnt_ff <= BUS_OE_N_OUT ? high_cnt_ff + 1'b1 : '0;
      after_rst_ff <= BUS_OE_N_OUT && (after_rst_ff || long_low);
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  reset_length_a: assert property (
    $rose(BUS_OE_N_OUT) && long_low && !FAST_SPEED_OUT |->
    low_cnt_ff + 1'b1 >= RST_LOW_REG) else $error("reset pulse too short");
  release_gap_a: assert property (
    $fell(BUS_OE_N_OUT) && after_rst_ff |->
    high_cnt_ff + 2'd2 >= (FAST_SPEED_OUT ? RST_HIGH_FAST : RST_HIGH_REG))
    else $error("presence window cut short");
  idle_released_a: assert property (!BUSY_OUT |-> BUS_OE_N_OUT)
    else $error("line held low while idle");
  slot_in_op_a: assert property ($fell(BUS_OE_N_OUT) |-> BUSY_OUT)
    else $error("line pulled low outside an operation");
  take_busy_a: assert property (take |=> BUSY_OUT && !CMD_READY_OUT)
    else $error("command taken without starting");
  first_low_a: assert property (take |-> ##[1:3] $fell(BUS_OE_N_OUT))
    else $error("operation did not start with a low");
  flag_change_a: assert property (
    $changed(FAST_SPEED_OUT) |-> BUSY_OUT || $past(BUSY_OUT) || $past(take))
    else $error("speed flag moved while idle");
  rsp_hold_a: assert property (
    RSP_VALID_OUT && !RSP_READY_IN |=> RSP_VALID_OUT && $stable(RSP_OUT))
    else $error("answer changed while stalled");
endmodule : swr_master_chk

bind swr_master swr_master_chk #(
  .CW(CW), .LOW0_REG(LOW0_REG), .RST_LOW_REG(RST_LOW_REG),
  .RST_HIGH_REG(RST_HIGH_REG), .RST_HIGH_FAST(RST_HIGH_FAST)
) i_chk (
  .CLK_SYS_IN(CLK_SYS_IN), .RESET_N_IN(RESET_N_IN),
  .CMD_VALID_IN(CMD_VALID_IN), .CMD_READY_OUT(CMD_READY_OUT),
  .RSP_VALID_OUT(RSP_VALID_OUT), .RSP_OUT(RSP_OUT),
  .RSP_READY_IN(RSP_READY_IN), .BUS_OE_N_OUT(BUS_OE_N_OUT),
  .FAST_SPEED_OUT(FAST_SPEED_OUT), .BUSY_OUT(BUSY_OUT)
);

//--- swr_master_tb.sv
`timescale 1ns/1ps

module swr_master_tb;
  // Arbitrary identity, shared with the device model
  localparam logic [63:0] ID = 64'h5a3c_0f96_d2e1_7b48;
  logic clk, rst_n, cmd_valid, cmd_ready, rsp_valid, rsp_ready;
  logic bus_out, bus_oe_n, fast, busy, present, pull_n, line;
  swr_pkg::swr_cmd_s cmd;
  swr_pkg::swr_rsp_s rsp;
  logic [17:0] exp_q[$];
  logic [17:0] e;
  int mismatches, n_checks, seed;

  // Open-drain line with pull-up
  assign line = (bus_oe_n | bus_out) & pull_n;

  // Fast timing runs at its defaults; only regular timing is shortened
  swr_master #(
    .RST_LOW_REG(17'h32c8), .RST_HIGH_REG(17'hc80), .PRES_SAMP_REG(17'h7d0),
    .LOW0_REG(17'h7d0), .SLOT_REG(17'hc80)
  ) i_dut (
    .CLK_SYS_IN(clk), .RESET_N_IN(rst_n), .CMD_VALID_IN(cmd_valid),
    .CMD_IN(cmd), .CMD_READY_OUT(cmd_ready), .RSP_VALID_OUT(rsp_valid),
    .RSP_OUT(rsp), .RSP_READY_IN(rsp_ready), .BUS_IN(line),
    .BUS_OUT(bus_out), .BUS_OE_N_OUT(bus_oe_n), .FAST_SPEED_OUT(fast),
    .BUSY_OUT(busy)
  );

  swr_dev_model #(.ID(ID)) i_dev (
    .line_in(line), .present_in(present), .pull_n_out(pull_n)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  task automatic report_and_stop();
    if (mismatches == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic want(input logic [1:0] k, input logic [7:0] m,
                      input logic [7:0] d);
    exp_q.push_back({k, m, d});
  endtask : want

  // Called at a falling edge; holds the offer until it is taken
  task automatic do_cmd(input swr_pkg::swr_op_e op, input logic [7:0] d);
    int n;
    n = 0;
    cmd.op = op;
    cmd.data = d;
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1 && n < 60000) begin
      @(negedge clk);
      n++;
    end
    check("command wait", 8'(n == 60000), 8'h00);
    @(negedge clk);
    cmd_valid = 1'b0;
    // Let an edge pass so a following offer never reuses this time step
    @(negedge clk);
  endtask : do_cmd

  task automatic settle();
    int n;
    n = 0;
    while ((busy !== 1'b0 || exp_q.size() != 0) && n < 60000) begin
      @(negedge clk);
      n++;
    end
    check("settle time", 8'(n == 60000), 8'h00);
  endtask : settle

  // Answers are compared while offered; the ready line stalls at random
  // Ready is chosen first, so every word popped at the next edge is seen
  always @(negedge clk) begin
    rsp_ready = 1'($random(seed));
    if (rsp_valid === 1'b1 && rsp_ready === 1'b1) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : '1;
      check("answer kind", {6'h00, rsp.kind}, {6'h00, e[17:16]});
      check("answer data", rsp.data & e[15:8], e[7:0]);
    end
  end

  // About 182k cycles of traffic, with margin
  initial begin
    #1000000;
    mismatches++;
    report_and_stop();
  end

  initial begin
    seed = 32'h666972ad;
    mismatches = 0;
    n_checks = 0;
    rst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd = '0;
    present = 1'b0;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    check("speed flag", {7'h00, fast}, 8'h00);
    want(swr_pkg::SWR_RSP_PRESENCE, 8'h01, 8'h00);
    do_cmd(swr_pkg::SWR_OP_RESET_REG, 8'h00);
    settle();
    present = 1'b1;
    want(swr_pkg::SWR_RSP_PRESENCE, 8'h01, 8'h01);
    do_cmd(swr_pkg::SWR_OP_RESET_REG, 8'h00);
    do_cmd(swr_pkg::SWR_OP_WRITE, 8'h3c);
    settle();
    check("speed flag", {7'h00, fast}, 8'h01);
    // Short reset at fast speed must keep the flag
    want(swr_pkg::SWR_RSP_PRESENCE, 8'h01, 8'h01);
    do_cmd(swr_pkg::SWR_OP_RESET, 8'h00);
    do_cmd(swr_pkg::SWR_OP_WRITE, 8'h33);
    want(swr_pkg::SWR_RSP_BYTE, 8'hff, ID[7:0]);
    do_cmd(swr_pkg::SWR_OP_READ, 8'h00);
    settle();
    check("speed flag", {7'h00, fast}, 8'h01);
    want(swr_pkg::SWR_RSP_PRESENCE, 8'h01, 8'h01);
    do_cmd(swr_pkg::SWR_OP_RESET, 8'h00);
    do_cmd(swr_pkg::SWR_OP_WRITE, 8'hf0);
    for (int i = 0; i < 2; i++) begin
      want(swr_pkg::SWR_RSP_TRIPLET, 8'h07, {5'h00, ID[i], ~ID[i], ID[i]});
      do_cmd(swr_pkg::SWR_OP_TRIPLET, 8'($random(seed)));
    end
    settle();
    // Long reset returns everyone to regular speed
    want(swr_pkg::SWR_RSP_PRESENCE, 8'h01, 8'h01);
    do_cmd(swr_pkg::SWR_OP_RESET_REG, 8'h00);
    settle();
    check("speed flag", {7'h00, fast}, 8'h00);
    report_and_stop();
  end
endmodule : swr_master_tb

//--- swr_pkg.sv
package swr_pkg;

  typedef enum logic [2:0] {
    SWR_OP_RESET,
    SWR_OP_RESET_REG,
    SWR_OP_WRITE,
    SWR_OP_READ,
    SWR_OP_TRIPLET
  } swr_op_e;

  typedef enum logic [1:0] {
    SWR_RSP_PRESENCE,
    SWR_RSP_BYTE,
    SWR_RSP_TRIPLET
  } swr_rsp_e;

  typedef struct packed {
    swr_op_e op;
    logic [7:0] data;
  } swr_cmd_s;

  typedef struct packed {
    swr_rsp_e kind;
    logic [7:0] data;
  } swr_rsp_s;

endpackage : swr_pkg
